// ===== verilog/vector_map_pkg.sv
// Package of vector map constants, types and slot offsets
package vector_map_pkg;
    // ------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------
    localparam int ADDR_W = 14;
    localparam int NUM_IRQ = 25;
    localparam int IDX_W = 5;
    localparam int SLOT_WORDS = 2;

    // ------------------------------------------------------------
    // Fixed addresses
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] RESET_VECTOR_ADDR = 14'h0000;
    localparam logic [ADDR_W-1:0] IRQ_BASE_OFFSET = 14'h0002;
    localparam logic [ADDR_W-1:0] DEFAULT_BOOT_ADDR = 14'h1c00;
    localparam logic FUSE_PROGRAMMED = 1'b0;

    // ------------------------------------------------------------
    // Source indices, lowest index = lowest vector number
    // ------------------------------------------------------------
    localparam int SRC_EXT_IRQ_ZERO = 0;
    localparam int SRC_EXT_IRQ_ONE = 1;
    localparam int SRC_PIN_CHANGE_IRQ_ZERO = 2;
    localparam int SRC_PIN_CHANGE_IRQ_ONE = 3;
    localparam int SRC_PIN_CHANGE_IRQ_TWO = 4;
    localparam int SRC_WATCHDOG_TIMEOUT_IRQ = 5;
    localparam int SRC_TIMER2_COMPARE_A = 6;
    localparam int SRC_TIMER2_COMPARE_B = 7;
    localparam int SRC_TIMER2_OVERFLOW = 8;
    localparam int SRC_TIMER1_CAPTURE = 9;
    localparam int SRC_TIMER1_COMPARE_A = 10;
    localparam int SRC_TIMER1_COMPARE_B = 11;
    localparam int SRC_TIMER1_OVERFLOW = 12;
    localparam int SRC_TIMER0_COMPARE_A = 13;
    localparam int SRC_TIMER0_COMPARE_B = 14;
    localparam int SRC_TIMER0_OVERFLOW = 15;
    localparam int SRC_SPI_DONE = 16;
    localparam int SRC_USART_RX_DONE = 17;
    localparam int SRC_USART_DATA_EMPTY = 18;
    localparam int SRC_USART_TX_DONE = 19;
    localparam int SRC_ADC_DONE = 20;
    localparam int SRC_EEPROM_READY_IRQ = 21;
    localparam int SRC_ANALOG_COMPARE = 22;
    localparam int SRC_TWO_WIRE_IRQ = 23;
    localparam int SRC_SELF_PROGRAM_READY_IRQ = 24;

    typedef enum logic [2:0] {
        ST_RESET_VEC = 3'b001,
        ST_IDLE = 3'b010,
        ST_IRQ_VEC = 3'b100
    } vec_state_t;

    // Base-table offset of source idx: 0x0002 + 2*idx
    function automatic logic [ADDR_W-1:0] slot_offset(
        input logic [IDX_W-1:0] idx
    );
        logic [ADDR_W-1:0] wide;
        wide = ADDR_W'(idx);
        slot_offset = IRQ_BASE_OFFSET + ADDR_W'(wide * SLOT_WORDS);
    endfunction
endpackage

// ===== verilog/vector_req_if.sv
// Interface carrying a winning request between encoder and mapper
`timescale 1ns/1ps
interface vector_req_if;
    import vector_map_pkg::*;
    logic valid;
    logic [IDX_W-1:0] index;
    modport producer (output valid, output index);
    modport consumer (input valid, input index);
endinterface

// ===== verilog/irq_priority_encoder.sv
// Fixed priority encoder: lowest source index wins
`timescale 1ns/1ps
module irq_priority_encoder
    import vector_map_pkg::*;
#(
    parameter int N = NUM_IRQ
) (
    input wire logic [N-1:0] i_req,
    vector_req_if.producer req
);
    logic [IDX_W-1:0] win_idx;

    // ------------------------------------------------------------
    // Search from top down so lowest index is assigned last
    // ------------------------------------------------------------
    always_comb begin
        win_idx = '0;
        for (int k = N - 1; k >= 0; k--) begin
            if (i_req[k]) begin
                win_idx = IDX_W'(k);
            end
        end
    end

    assign req.valid = |i_req;
    assign req.index = win_idx;
endmodule

// ===== verilog/reset_interrupt_vector_map.sv
// Reset and interrupt vector address map for the core fetch logic
// Function
// - Reset vectors to address 0x0000 when boot fuse is unprogrammed.
// - External request zero at 0x0002, request one at 0x0004.
// - Three pin-change requests at 0x0006..0x000A, watchdog at 0x000C.
// - Timer two compare A, compare B, overflow at 0x000E..0x0012.
// - Timer one capture, compare A, B, overflow at 0x0014..0x001A.
// - Timer zero compare A, compare B, overflow at 0x001C..0x0020.
// - SPI at 0x0022, then USART receive, empty, transmit to 0x0028.
// - ADC 0x002A, EEPROM, comparator, two-wire, self-program last 0x0032.
// - Vector select bit moves interrupt table, not reset, to boot start.
// - Relocated vector equals boot start plus base-table offset.
// - Programmed boot fuse starts execution at the boot loader address.
// - Reset address from fuse only; interrupt base from select bit only.
// - Fuse value 1 means unprogrammed, 0 means programmed.
// - Unused vector slots are plain program memory, no special handling.
// - Unused slots in either section may hold regular code.
`timescale 1ns/1ps
module reset_interrupt_vector_map
    import vector_map_pkg::*;
#(
    parameter logic [ADDR_W-1:0] BOOT_RESET_ADDR = DEFAULT_BOOT_ADDR
) (
    input wire logic I_MCLK,
    input wire logic I_RESETN,
    input wire logic I_BOOT_RESET_SELECT_FUSE,
    input wire logic I_VECTOR_TABLE_SELECT_BIT,
    input wire logic [NUM_IRQ-1:0] I_IRQ_PENDING,
    input wire logic I_VECTOR_ACK,
    output logic O_VECTOR_VALID,
    output logic O_VECTOR_IS_RESET,
    output logic [ADDR_W-1:0] O_VECTOR_ADDR,
    output logic [IDX_W-1:0] O_VECTOR_INDEX,
    output logic [ADDR_W-1:0] O_RESET_ADDR,
    output logic [ADDR_W-1:0] O_IRQ_BASE_ADDR
);
    // ------------------------------------------------------------
    // Priority selection
    // ------------------------------------------------------------
    vector_req_if req_bus ();

    irq_priority_encoder #(
        .N(NUM_IRQ)
    ) irq_priority_encoder_i (
        .i_req(I_IRQ_PENDING),
        .req(req_bus.producer)
    );

    // ------------------------------------------------------------
    // Address decoding
    // ------------------------------------------------------------
    // Fuse reads 0 when programmed
    wire boot_fuse_programmed = (I_BOOT_RESET_SELECT_FUSE
                                 == FUSE_PROGRAMMED);
    // Reset address depends on the fuse alone
    wire [ADDR_W-1:0] reset_addr_sel = boot_fuse_programmed
        ? BOOT_RESET_ADDR
        : RESET_VECTOR_ADDR;
    // Table start depends on the select bit alone
    wire [ADDR_W-1:0] table_start = I_VECTOR_TABLE_SELECT_BIT
        ? BOOT_RESET_ADDR
        : '0;
    wire [ADDR_W-1:0] irq_base_sel = table_start + IRQ_BASE_OFFSET;
    // Slot offsets follow source order, two words each
    wire [ADDR_W-1:0] win_offset =
        slot_offset(req_bus.index);
    wire [ADDR_W-1:0] irq_addr_sel = table_start + win_offset;
    wire take_irq = req_bus.valid;

    // ------------------------------------------------------------
    // Vector sequencer
    // ------------------------------------------------------------
    // No interrupt slot is fetched unless its request is pending, so unused slots
    // stay ordinary program memory to the core.
    vec_state_t state_reg;
    vec_state_t state_next;
    logic valid_next;
    logic is_reset_next;
    logic [ADDR_W-1:0] addr_next;
    logic [IDX_W-1:0] index_next;
    logic valid_reg;
    logic is_reset_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [IDX_W-1:0] index_reg;
    logic [ADDR_W-1:0] reset_addr_reg;
    logic [ADDR_W-1:0] irq_base_reg;

    always_comb begin
        state_next = state_reg;
        valid_next = valid_reg;
        is_reset_next = is_reset_reg;
        addr_next = addr_reg;
        index_next = index_reg;
        unique case (state_reg)
            ST_RESET_VEC: begin
                // Present reset target after any system reset
                valid_next = 1'b1;
                is_reset_next = 1'b1;
                addr_next = reset_addr_sel;
                index_next = '0;
                if (valid_reg && I_VECTOR_ACK) begin
                    state_next = ST_IDLE;
                    valid_next = 1'b0;
                    is_reset_next = 1'b0;
                end
            end
            ST_IDLE: begin
                if (take_irq) begin
                    state_next = ST_IRQ_VEC;
                    valid_next = 1'b1;
                    addr_next = irq_addr_sel;
                    index_next = req_bus.index;
                end
            end
            ST_IRQ_VEC: begin
                // Hold the taken vector stable until the core accepts it
                if (I_VECTOR_ACK) begin
                    state_next = ST_IDLE;
                    valid_next = 1'b0;
                end
            end
            default: begin
                state_next = ST_RESET_VEC;
                valid_next = 1'b0;
                is_reset_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge I_MCLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            state_reg <= ST_RESET_VEC;
            valid_reg <= 1'b0;
            is_reset_reg <= 1'b0;
            addr_reg <= RESET_VECTOR_ADDR;
            index_reg <= '0;
            reset_addr_reg <= RESET_VECTOR_ADDR;
            irq_base_reg <= IRQ_BASE_OFFSET;
        end else begin
            state_reg <= state_next;
            valid_reg <= valid_next;
            is_reset_reg <= is_reset_next;
            addr_reg <= addr_next;
            index_reg <= index_next;
            reset_addr_reg <= reset_addr_sel;
            irq_base_reg <= irq_base_sel;
        end
    end

    assign O_VECTOR_VALID = valid_reg;
    assign O_VECTOR_IS_RESET = is_reset_reg;
    assign O_VECTOR_ADDR = addr_reg;
    assign O_VECTOR_INDEX = index_reg;
    assign O_RESET_ADDR = reset_addr_reg;
    assign O_IRQ_BASE_ADDR = irq_base_reg;
endmodule

// ===== tb/vector_map_monitor.sv
// Checker of vector presentation and address relations
`timescale 1ns/1ps
module vector_map_monitor
    import vector_map_pkg::*;
#(
    parameter logic [ADDR_W-1:0] BOOT_RESET_ADDR = DEFAULT_BOOT_ADDR
) (
    input wire logic I_MCLK, input wire logic I_RESETN,
    input wire logic I_BOOT_RESET_SELECT_FUSE,
    input wire logic I_VECTOR_TABLE_SELECT_BIT,
    input wire logic [NUM_IRQ-1:0] I_IRQ_PENDING, input wire logic I_VECTOR_ACK,
    input wire logic O_VECTOR_VALID, input wire logic O_VECTOR_IS_RESET,
    input wire logic [ADDR_W-1:0] O_VECTOR_ADDR,
    input wire logic [IDX_W-1:0] O_VECTOR_INDEX,
    input wire logic [ADDR_W-1:0] O_RESET_ADDR,
    input wire logic [ADDR_W-1:0] O_IRQ_BASE_ADDR
);
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_RESETN);
    // --------------------------------
    // Properties
    // --------------------------------
    AST_RESET_FIRST: assert property (I_RESETN && !$past(I_RESETN) |=>
        O_VECTOR_VALID && O_VECTOR_IS_RESET && O_VECTOR_ADDR ==
        ($past(I_BOOT_RESET_SELECT_FUSE) ? 14'h0000 : BOOT_RESET_ADDR))
        else $error("reset vector wrong");
    AST_RESET_PORT: assert property ($past(I_RESETN) |-> O_RESET_ADDR ==
        ($past(I_BOOT_RESET_SELECT_FUSE) ? 14'h0000 : BOOT_RESET_ADDR))
        else $error("reset address wrong");
    AST_BASE_PORT: assert property ($past(I_RESETN) |->
        O_IRQ_BASE_ADDR == ($past(I_VECTOR_TABLE_SELECT_BIT) ? BOOT_RESET_ADDR
        : 14'h0000) + 14'h0002) else $error("table base wrong");
    AST_VALID_HOLD: assert property (O_VECTOR_VALID && !I_VECTOR_ACK |=>
        O_VECTOR_VALID && $stable(O_VECTOR_ADDR) && $stable(O_VECTOR_INDEX))
        else $error("vector not held");
    AST_VALID_DROP: assert property (O_VECTOR_VALID && I_VECTOR_ACK
        |=> !O_VECTOR_VALID) else $error("vector not dropped");
    AST_IRQ_ADDR: assert property ($rose(O_VECTOR_VALID) &&
        !O_VECTOR_IS_RESET |-> O_VECTOR_ADDR ==
        ($past(I_VECTOR_TABLE_SELECT_BIT) ? BOOT_RESET_ADDR : 14'h0000)
        + 14'h0002 + {8'h00, O_VECTOR_INDEX, 1'b0})
        else $error("vector address wrong");
    AST_PRIORITY: assert property ($rose(O_VECTOR_VALID) &&
        !O_VECTOR_IS_RESET |-> ($past(I_IRQ_PENDING) & (~$past(I_IRQ_PENDING)
        + 25'h1)) == (25'h1 << O_VECTOR_INDEX)) else $error("wrong winner");
    AST_IRQ_ANSWER: assert property ($past(I_RESETN) &&
        !O_VECTOR_VALID && |I_IRQ_PENDING |=> O_VECTOR_VALID &&
        !O_VECTOR_IS_RESET) else $error("request not taken");
    cover property ($rose(O_VECTOR_IS_RESET));
    cover property ($rose(O_VECTOR_VALID) && I_VECTOR_TABLE_SELECT_BIT);
    cover property (O_VECTOR_VALID && !I_VECTOR_ACK ##1 I_VECTOR_ACK);
endmodule

// ===== tb/fetch_core_model.sv
// Core fetch side: accepts each vector after a chosen delay
`timescale 1ns/1ps
module fetch_core_model (
    input wire logic i_clk,
    input wire logic i_valid,
    input wire logic [3:0] i_delay,
    output logic o_ack
);
    logic [3:0] cnt_reg;
    initial begin
        o_ack = 1'b0;
        cnt_reg = 4'h0;
    end
    // Acts off the falling edge so ack is settled when sampled
    always @(negedge i_clk) begin
        o_ack <= i_valid && !o_ack && cnt_reg >= i_delay;
        cnt_reg <= (i_valid && !o_ack) ? cnt_reg + 4'h1 : 4'h0;
    end
endmodule

// ===== tb/reset_interrupt_vector_map_test.sv
// Self-checking bench of the vector map block
`timescale 1ns/1ps
module reset_interrupt_vector_map_test;
    import vector_map_pkg::*;
    localparam logic [ADDR_W-1:0] BA = DEFAULT_BOOT_ADDR;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic fuse = 1'b1;
    logic sel = 1'b0;
    logic [NUM_IRQ-1:0] pend = '0;
    logic [3:0] dly = 4'h0;
    logic ack, vld, isr;
    logic [ADDR_W-1:0] addr, rsa, iba;
    logic [IDX_W-1:0] idx;
    int num_errors = 0;
    int num_checks = 0;
    always #4 clk = ~clk;
    reset_interrupt_vector_map #(.BOOT_RESET_ADDR(BA))
        reset_interrupt_vector_map_i (.I_MCLK(clk), .I_RESETN(rst_n),
        .I_BOOT_RESET_SELECT_FUSE(fuse), .I_VECTOR_TABLE_SELECT_BIT(sel),
        .I_IRQ_PENDING(pend), .I_VECTOR_ACK(ack), .O_VECTOR_VALID(vld),
        .O_VECTOR_IS_RESET(isr), .O_VECTOR_ADDR(addr), .O_VECTOR_INDEX(idx),
        .O_RESET_ADDR(rsa), .O_IRQ_BASE_ADDR(iba));
    fetch_core_model fetch_core_model_i (.i_clk(clk), .i_valid(vld),
        .i_delay(dly), .o_ack(ack));
    // --------------------------------
    // Helpers
    // --------------------------------
    task check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task stop_test;
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Bounded so a stuck handshake cannot hang the run
    task wait_for(input logic v);
        for (int n = 0; n < 40 && vld !== v; n++) @(negedge clk);
        check(vld, v);
    endtask
    // --------------------------------
    // Scenarios
    // --------------------------------
    task reset_boot(input logic f);
        @(negedge clk);
        rst_n = 1'b0;
        fuse = f;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        wait_for(1'b1);
        check(isr, 1'b1);
        check(addr, f ? 14'h0000 : BA);
        wait_for(1'b0);
    endtask
    task addr_ports;
        for (int c = 0; c < 4; c++) begin
            {fuse, sel} = c[1:0];
            repeat (2) @(negedge clk);
            check(rsa, fuse ? 14'h0000 : BA);
            check(iba, (sel ? BA : 14'h0000) + 14'h0002);
        end
    endtask
    task sweep(input logic s);
        sel = s;
        for (int i = 0; i < NUM_IRQ; i++) begin
            pend = NUM_IRQ'(1) << i;
            wait_for(1'b1);
            pend = '0;
            check(idx, i[IDX_W-1:0]);
            check(addr, (s ? BA : 14'h0000) + 14'(2 * i + 2));
            wait_for(1'b0);
        end
    endtask
    task priority_pick;
        dly = 4'h5;
        sel = 1'b0;
        pend = 25'h0000088;
        wait_for(1'b1);
        check(idx, 5'h03);
        pend = 25'h1000001;
        repeat (3) @(negedge clk);
        check(addr, 14'h0008);
        wait_for(1'b0);
        wait_for(1'b1);
        check(addr, 14'h0002);
        pend = '0;
        wait_for(1'b0);
        dly = 4'h0;
    endtask
    initial begin
        reset_boot(1'b1);
        addr_ports;
        sweep(1'b0);
        reset_boot(1'b0);
        sweep(1'b1);
        priority_pick;
        stop_test;
    end
    initial begin
        #100000;
        num_errors++;
        stop_test;
    end
endmodule
bind reset_interrupt_vector_map vector_map_monitor #(
    .BOOT_RESET_ADDR(BOOT_RESET_ADDR)) vector_map_monitor_i (
    .I_MCLK(I_MCLK), .I_RESETN(I_RESETN),
    .I_BOOT_RESET_SELECT_FUSE(I_BOOT_RESET_SELECT_FUSE),
    .I_VECTOR_TABLE_SELECT_BIT(I_VECTOR_TABLE_SELECT_BIT),
    .I_IRQ_PENDING(I_IRQ_PENDING), .I_VECTOR_ACK(I_VECTOR_ACK),
    .O_VECTOR_VALID(O_VECTOR_VALID), .O_VECTOR_IS_RESET(O_VECTOR_IS_RESET),
    .O_VECTOR_ADDR(O_VECTOR_ADDR), .O_VECTOR_INDEX(O_VECTOR_INDEX),
    .O_RESET_ADDR(O_RESET_ADDR), .O_IRQ_BASE_ADDR(O_IRQ_BASE_ADDR));
